// File: bench/ept_cpu_model.sv
// CPU software model driving the timer's single-cycle register port
// Assumes strobes are sampled at the rising edge of clk_i
`include "ept_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ept_cpu_model (
  input  wire logic        clk_i,
  output logic      [15:0] addr_o,
  output logic             wr_en_o,
  output logic             rd_en_o,
  output logic      [7:0]  wdata_o,
  input  wire logic [7:0]  rdata_i
);
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  initial begin
    addr_o = 16'h0000;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_en_o = 1'b0;
    addr_o = ~a;
    @(posedge clk_i);
    #1;
    d = rdata_i;
  endtask
  // Stop, then switch bits, then clock code with upper bits zero
  task automatic setup(input logic [2:0] code, input logic [3:0] sw);
    wr(`EPT_ADDR_MODE, 8'h00);
    wr(`EPT_ADDR_CSW, {4'h0, sw});
    wr(`EPT_ADDR_CLK, {5'h00, code});
  endtask
endmodule
`default_nettype wire

// File: bench/ept_timer_bench.sv
// Self-checking bench of the eight-bit interval/PWM timer
// Assumes the monitor is bound by its own file and the CPU model drives the port
`include "ept_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ept_timer_bench;
  // ----------------------------------------
  // Clock, reset, design and CPU model
  // ----------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [15:0] addr_i;
  logic        wr_en_i;
  logic        rd_en_i;
  logic [7:0]  wdata_i;
  logic [7:0]  rdata_o;
  logic        match_interrupt_request_o;
  logic        timer_output_o;
  logic        pwm_output_o;
  logic        sw_a;
  logic        sw_b;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #5 clk_i = ~clk_i;
  ept_timer ept_timer_inst (.clk_i, .rst_i, .addr_i, .wr_en_i, .rd_en_i, .wdata_i, .rdata_o,
    .match_interrupt_request_o, .timer_output_o, .pwm_output_o,
    .other_timer_a_clock_switch_o(sw_a), .other_timer_b_clock_switch_o(sw_b));
  ept_cpu_model ept_cpu_model_inst (.clk_i, .addr_o(addr_i), .wr_en_o(wr_en_i),
    .rd_en_o(rd_en_i), .wdata_o(wdata_i), .rdata_i(rdata_o));
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input string what, input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    ept_cpu_model_inst.rd(a, d);
    chk(what, {8'h00, exp}, {8'h00, d});
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic irq_gap(output int gap);
    int n;
    n = 0;
    while (match_interrupt_request_o !== 1'b1 && n < 20000) begin
      pause(1);
      n++;
    end
    gap = 0;
    do begin
      pause(1);
      gap++;
    end while (match_interrupt_request_o !== 1'b1 && gap < 20000);
  endtask
  // Active cycles over one 256-tick period
  task automatic pwm_width(input string what, input logic lvl, input int w);
    int n;
    pause(300);
    n = 0;
    repeat (256) begin
      pause(1);
      if (pwm_output_o === lvl) n++;
    end
    chk(what, 16'(w), 16'(n));
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rdchk("counter reset", `EPT_ADDR_CNT, 8'h00);
    rdchk("compare reset", `EPT_ADDR_CMP, 8'h00);
    rdchk("clock reset", `EPT_ADDR_CLK, 8'h00);
    rdchk("mode reset", `EPT_ADDR_MODE, 8'h00);
    rdchk("switch reset", `EPT_ADDR_CSW, 8'h00);
    ept_cpu_model_inst.wr(`EPT_ADDR_CMP, 8'hFF);
    rdchk("compare max", `EPT_ADDR_CMP, 8'hFF);
    ept_cpu_model_inst.wr(`EPT_ADDR_CNT, 8'h5A);
    rdchk("counter read only", `EPT_ADDR_CNT, 8'h00);
    ept_cpu_model_inst.wr(`EPT_ADDR_CSW, 8'hFF);
    rdchk("switch bits", `EPT_ADDR_CSW, 8'h0F);
    chk("switch pins", 16'h0003, {14'h0, sw_b, sw_a});
    ept_cpu_model_inst.wr(`EPT_ADDR_MODE, 8'h7F);
    rdchk("mode bits", `EPT_ADDR_MODE, 8'h42);
    pause(3);
    chk("pwm stopped level", 16'h0001, {15'h0, pwm_output_o});
    ept_cpu_model_inst.wr(16'hFF70, 8'hFF);
    rdchk("unmapped", 16'hFF70, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_levels;
    ept_cpu_model_inst.setup(`EPT_CODE_STOP, 4'h0);
    ept_cpu_model_inst.wr(`EPT_ADDR_MODE, 8'h08);
    pause(3);
    chk("output set", 16'h0001, {15'h0, timer_output_o});
    ept_cpu_model_inst.wr(`EPT_ADDR_MODE, 8'h0C);
    pause(3);
    chk("output prohibited", 16'h0001, {15'h0, timer_output_o});
    ept_cpu_model_inst.wr(`EPT_ADDR_MODE, 8'h04);
    pause(3);
    chk("output reset", 16'h0000, {15'h0, timer_output_o});
    $display("test output levels done");
  endtask
  task automatic t_interval;
    int g;
    logic prev;
    logic [7:0] d;
    ept_cpu_model_inst.setup(`EPT_CODE_DIV1, 4'h0);
    ept_cpu_model_inst.wr(`EPT_ADDR_CMP, 8'h03);
    ept_cpu_model_inst.wr(`EPT_ADDR_MODE, 8'h82);
    irq_gap(g);
    chk("interval", 16'd4, 16'(g));
    prev = timer_output_o;
    pause(1);
    chk("square toggle", {15'h0, ~prev}, {15'h0, timer_output_o});
    ept_cpu_model_inst.rd(`EPT_ADDR_CNT, d);
    chk("count below compare", 16'h0001, {15'h0, d <= 8'h03});
    ept_cpu_model_inst.wr(`EPT_ADDR_MODE, 8'h02);
    rdchk("count cleared", `EPT_ADDR_CNT, 8'h00);
    $display("test interval done");
  endtask
  task automatic t_codes;
    logic [2:0] codes [8] = '{3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h6, 3'h6, 3'h7};
    logic [3:0] sws [8] = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h0, 4'h0, 4'h8, 4'h0};
    int divs [8] = '{1, 2, 4, 16, 64, 256, 2048, 8192};
    int g;
    int hits;
    ept_cpu_model_inst.wr(`EPT_ADDR_CMP, 8'h00);
    for (int i = 0; i < 8; i++) begin
      ept_cpu_model_inst.setup(codes[i], sws[i]);
      ept_cpu_model_inst.wr(`EPT_ADDR_MODE, 8'h80);
      irq_gap(g);
      chk("divider", 16'(divs[i]), 16'(g));
    end
    for (int c = 0; c < 2; c++) begin
      ept_cpu_model_inst.setup(3'(c), 4'hC);
      ept_cpu_model_inst.wr(`EPT_ADDR_MODE, 8'h80);
      hits = 0;
      repeat (400) begin
        pause(1);
        if (match_interrupt_request_o !== 1'b0) hits++;
      end
      chk("no count clock", 16'h0000, 16'(hits));
    end
    $display("test clock codes done");
  endtask
  task automatic t_pwm;
    ept_cpu_model_inst.setup(`EPT_CODE_DIV1, 4'h0);
    ept_cpu_model_inst.wr(`EPT_ADDR_CMP, 8'h40);
    ept_cpu_model_inst.wr(`EPT_ADDR_MODE, 8'hC0);
    pwm_width("pwm high width", 1'b1, 64);
    ept_cpu_model_inst.wr(`EPT_ADDR_CMP, 8'h80);
    pwm_width("pwm rewritten width", 1'b1, 128);
    ept_cpu_model_inst.wr(`EPT_ADDR_MODE, 8'h40);
    ept_cpu_model_inst.wr(`EPT_ADDR_MODE, 8'hC2);
    pwm_width("pwm low width", 1'b0, 128);
    ept_cpu_model_inst.wr(`EPT_ADDR_MODE, 8'h42);
    pause(3);
    chk("pwm off inactive", 16'h0001, {15'h0, pwm_output_o});
    $display("test pwm done");
  endtask
  initial begin
    pause(2);
    rst_i = 1'b0;
    t_regs();
    t_levels();
    t_interval();
    t_codes();
    t_pwm();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: bench/ept_timer_monitor.sv
// Checker of the timer's register port and output pins
// Assumes it is bound to ept_timer and sees only its ports
`include "ept_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ept_timer_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] addr_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [7:0]  wdata_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        match_interrupt_request_o,
  input wire logic        timer_output_o,
  input wire logic        pwm_output_o,
  input wire logic        other_timer_a_clock_switch_o,
  input wire logic        other_timer_b_clock_switch_o
);
  // ----------------------------------------
  // Helper logic and assertions
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic pwm_seen_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_seen_reg <= 1'b0;
    end else if (wr_en_i && addr_i == `EPT_ADDR_MODE) begin
      pwm_seen_reg <= wdata_i[`EPT_MODE_PWM];
    end
  end
  a_switch_a_follows: assert property (wr_en_i && addr_i == `EPT_ADDR_CSW |=>
    other_timer_a_clock_switch_o == $past(wdata_i[0])) else $error("switch a wrong");
  a_switch_b_follows: assert property (wr_en_i && addr_i == `EPT_ADDR_CSW |=>
    other_timer_b_clock_switch_o == $past(wdata_i[1])) else $error("switch b wrong");
  a_clock_upper_zero: assert property (rd_en_i && addr_i == `EPT_ADDR_CLK |=>
    rdata_o[7:3] == 5'h00) else $error("clock select upper bits set");
  a_switch_upper_zero: assert property (rd_en_i && addr_i == `EPT_ADDR_CSW |=>
    rdata_o[7:4] == 4'h0) else $error("switch upper bits set");
  a_mode_unused_zero: assert property (rd_en_i && addr_i == `EPT_ADDR_MODE |=>
    rdata_o[5:2] == 4'h0 && !rdata_o[0]) else $error("mode unused bits set");
  a_reset_quiet: assert property ($fell(rst_i) |-> rdata_o == 8'h00 &&
    !timer_output_o && !pwm_output_o && !match_interrupt_request_o) else $error("reset not quiet");
  a_toggle_cause: assert property ($changed(timer_output_o) |->
    $past(match_interrupt_request_o) || $past(wr_en_i) || $past(wr_en_i, 2))
    else $error("timer output moved without cause");
  a_pwm_idle_low: assert property ((!pwm_seen_reg)[*3] |-> !pwm_output_o)
    else $error("pwm pin active outside pwm mode");
  c_irq: cover property (match_interrupt_request_o);
  c_toggle: cover property ($rose(timer_output_o));
  c_pwm: cover property ($rose(pwm_output_o));
endmodule
bind ept_timer ept_timer_monitor ept_timer_monitor_inst (.clk_i, .rst_i, .addr_i, .wr_en_i,
  .rd_en_i, .wdata_i, .rdata_o, .match_interrupt_request_o, .timer_output_o, .pwm_output_o,
  .other_timer_a_clock_switch_o, .other_timer_b_clock_switch_o);
`default_nettype wire

// File: inc/ept_core_if.sv
// Carrier between the timer core, its prescaler and its output unit
// Assumes all three run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface ept_core_if;
  logic [2:0] clk_code;
  logic       code4_sw;
  logic       code6_sw;
  logic       tick;
  logic       run;
  logic       pwm_mode;
  logic       lvl_sel;
  logic       set_p;
  logic       clr_p;
  logic       match_p;
  logic       ovf_p;
  logic       timer_ff;
  logic       pwm_pin;
  modport core (output clk_code, code4_sw, code6_sw, run, pwm_mode, lvl_sel,
                output set_p, clr_p, match_p, ovf_p,
                input tick, timer_ff, pwm_pin);
  modport presc (input clk_code, code4_sw, code6_sw, output tick);
  modport outu (input run, pwm_mode, lvl_sel, set_p, clr_p, match_p, ovf_p,
                output timer_ff, pwm_pin);
endinterface
`default_nettype wire

// File: inc/ept_defs.svh
// Register addresses, field positions, reset values and clock codes of the timer
// Assumes inclusion by bare name; holds definitions only
`ifndef EPT_DEFS_SVH
`define EPT_DEFS_SVH
`define EPT_ADDR_CNT    16'hFF16
`define EPT_ADDR_CMP    16'hFF17
`define EPT_ADDR_CLK    16'hFF6A
`define EPT_ADDR_MODE   16'hFF6B
`define EPT_ADDR_CSW    16'hFF71
`define EPT_RST_8       8'h00
`define EPT_MAX_8       8'hFF
`define EPT_ONE_8       8'h01
`define EPT_MODE_EN     7
`define EPT_MODE_PWM    6
`define EPT_MODE_SET    3
`define EPT_MODE_CLR    2
`define EPT_MODE_LVL    1
`define EPT_CSW_C6      3
`define EPT_CSW_C4      2
`define EPT_CSW_B       1
`define EPT_CSW_A       0
`define EPT_CODE_STOP   3'h0
`define EPT_CODE_NONE   3'h1
`define EPT_CODE_DIV1   3'h2
`define EPT_CODE_DIV2   3'h3
`define EPT_CODE_DIV4   3'h4
`define EPT_CODE_DIV64  3'h5
`define EPT_CODE_DIV256 3'h6
`define EPT_CODE_DIV8K  3'h7
`define EPT_MASK_D1     13'h0000
`define EPT_MASK_D2     13'h0001
`define EPT_MASK_D4     13'h0003
`define EPT_MASK_D16    13'h000F
`define EPT_MASK_D64    13'h003F
`define EPT_MASK_D256   13'h00FF
`define EPT_MASK_D2048  13'h07FF
`define EPT_MASK_D8192  13'h1FFF
`define EPT_DIV_ONE     13'h0001
`endif

// File: inc/ept_pkg.sv
// State types of the eight-bit interval/PWM timer
// Assumes no other package
package ept_pkg;
  typedef struct packed {
    logic [12:0] div_cnt;
    logic        tick;
  } ept_presc_t;
  typedef struct packed {
    logic timer_ff;
    logic pwm_act;
    logic pwm_pin;
  } ept_out_t;
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] cmp;
    logic [2:0] clk_code;
    logic [3:0] csw;
    logic       en;
    logic       pwm;
    logic       lvl;
    logic       set_p;
    logic       clr_p;
    logic       match_p;
    logic       ovf_p;
    logic [7:0] rdata;
  } ept_core_t;
endpackage

// File: verilog/ept_output_unit.sv
// Timer output flip-flop and PWM output flip-flop
// Assumes event pulses come registered from the core on the same clock
`timescale 1ns/100ps
`default_nettype none
module ept_output_unit (
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  ept_core_if.outu      cif
);
  ept_pkg::ept_out_t st_reg;
  ept_pkg::ept_out_t st_next;

  // ----------------------------------------
  // Output flip-flops
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    if (cif.set_p) begin
      st_next.timer_ff = 1'b1;
    end else if (cif.clr_p) begin
      st_next.timer_ff = 1'b0;
    end else if (cif.match_p && !cif.pwm_mode && cif.lvl_sel) begin
      st_next.timer_ff = !st_reg.timer_ff;
    end
    if (!cif.run || !cif.pwm_mode) begin
      st_next.pwm_act = 1'b0;
    end else if (cif.ovf_p) begin
      st_next.pwm_act = 1'b1;
    end else if (cif.match_p) begin
      st_next.pwm_act = 1'b0;
    end
    st_next.pwm_pin = cif.pwm_mode && (st_next.pwm_act ^ cif.lvl_sel);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cif.timer_ff = st_reg.timer_ff;
  assign cif.pwm_pin  = st_reg.pwm_pin;
endmodule
`default_nettype wire

// File: verilog/ept_prescaler.sv
// Count-clock prescaler: one-cycle tick at the selected division of clk_i
// Assumes clk_i is the high-speed system clock fx
`include "ept_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ept_prescaler (
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  ept_core_if.presc     cif
);
  ept_pkg::ept_presc_t st_reg;
  ept_pkg::ept_presc_t st_next;
  logic [12:0]         mask;
  logic                sel_ok;

  // ----------------------------------------
  // Clock code decode
  // ----------------------------------------
  always_comb begin
    mask   = `EPT_MASK_D1;
    sel_ok = 1'b1;
    case (cif.clk_code)
      `EPT_CODE_DIV1:   mask = `EPT_MASK_D1;
      `EPT_CODE_DIV2:   mask = `EPT_MASK_D2;
      `EPT_CODE_DIV4:   mask = cif.code4_sw ? `EPT_MASK_D16 : `EPT_MASK_D4;
      `EPT_CODE_DIV64:  mask = `EPT_MASK_D64;
      `EPT_CODE_DIV256: mask = cif.code6_sw ? `EPT_MASK_D2048 : `EPT_MASK_D256;
      `EPT_CODE_DIV8K:  mask = `EPT_MASK_D8192;
      default:          sel_ok = 1'b0;
    endcase
    st_next.div_cnt = st_reg.div_cnt + `EPT_DIV_ONE;
    st_next.tick    = sel_ok && ((st_reg.div_cnt & mask) == mask);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cif.tick = st_reg.tick;
endmodule
`default_nettype wire

// File: verilog/ept_timer.sv
// Eight-bit interval / square-wave / PWM timer with CPU register port
// Assumes a single-cycle CPU memory port on clk_i; clk_i is fx
`include "ept_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ept_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  output logic             match_interrupt_request_o,
  output logic             timer_output_o,
  output logic             pwm_output_o,
  output logic             other_timer_a_clock_switch_o,
  output logic             other_timer_b_clock_switch_o
);
  ept_pkg::ept_core_t st_reg;
  ept_pkg::ept_core_t st_next;
  ept_core_if         cif ();

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic       wr_cnt;
  logic       wr_cmp;
  logic       wr_clk;
  logic       wr_mode;
  logic       wr_csw;
  logic       hit;
  logic       at_max;
  logic [7:0] cnt_inc;
  logic       pwm_hit;
  logic [7:0] rd_val;
  logic [7:0] mode_rd;
  logic [7:0] clk_rd;
  logic [7:0] csw_rd;
  logic       new_en;
  logic       new_pwm;
  logic       new_set;
  logic       new_clr;

  always_comb begin
    wr_cnt  = wr_en_i && (addr_i == `EPT_ADDR_CNT);
    wr_cmp  = wr_en_i && (addr_i == `EPT_ADDR_CMP);
    wr_clk  = wr_en_i && (addr_i == `EPT_ADDR_CLK);
    wr_mode = wr_en_i && (addr_i == `EPT_ADDR_MODE);
    wr_csw  = wr_en_i && (addr_i == `EPT_ADDR_CSW);
  end

  // ----------------------------------------
  // Written mode fields
  // ----------------------------------------
  always_comb begin
    new_en  = wdata_i[`EPT_MODE_EN];
    new_pwm = wdata_i[`EPT_MODE_PWM];
    new_set = wdata_i[`EPT_MODE_SET];
    new_clr = wdata_i[`EPT_MODE_CLR];
  end

  // ----------------------------------------
  // Compare and overflow detect
  // ----------------------------------------
  always_comb begin
    hit    = (st_reg.cnt == st_reg.cmp);
    at_max = (st_reg.cnt == `EPT_MAX_8);
    // PWM match marks the tick on which the counter reaches compare
    cnt_inc = st_reg.cnt + `EPT_ONE_8;
    pwm_hit = (cnt_inc == st_reg.cmp);
  end

  // ----------------------------------------
  // Readback images
  // ----------------------------------------
  always_comb begin
    mode_rd                = `EPT_RST_8;
    mode_rd[`EPT_MODE_EN]  = st_reg.en;
    mode_rd[`EPT_MODE_PWM] = st_reg.pwm;
    mode_rd[`EPT_MODE_LVL] = st_reg.lvl;
    clk_rd                 = `EPT_RST_8;
    clk_rd[2:0]            = st_reg.clk_code;
    csw_rd                 = `EPT_RST_8;
    csw_rd[3:0]            = st_reg.csw;
  end

  always_comb begin
    case (addr_i)
      `EPT_ADDR_CNT: begin
        rd_val = st_reg.cnt;
      end
      `EPT_ADDR_CMP: begin
        rd_val = st_reg.cmp;
      end
      `EPT_ADDR_CLK: begin
        rd_val = clk_rd;
      end
      `EPT_ADDR_MODE: begin
        rd_val = mode_rd;
      end
      `EPT_ADDR_CSW: begin
        rd_val = csw_rd;
      end
      default: begin
        rd_val = `EPT_RST_8;
      end
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    st_next         = st_reg;
    st_next.set_p   = 1'b0;
    st_next.clr_p   = 1'b0;
    st_next.match_p = 1'b0;
    st_next.ovf_p   = 1'b0;

    // Counting on the selected count clock
    if (!st_reg.en) begin
      st_next.cnt = `EPT_RST_8;
    end else if (cif.tick) begin
      st_next.match_p = st_reg.pwm ? pwm_hit : hit;
      st_next.ovf_p   = at_max;
      if (hit && !st_reg.pwm) begin
        st_next.cnt = `EPT_RST_8;
      end else begin
        st_next.cnt = st_reg.cnt + `EPT_ONE_8;
      end
    end

    // Counter is read-only: writes to it are dropped
    if (wr_cnt) begin
      st_next.cnt = st_next.cnt;
    end

    // Compare register takes any value
    if (wr_cmp) begin
      st_next.cmp = wdata_i;
    end

    // Clock selection, upper bits not stored
    if (wr_clk) begin
      st_next.clk_code = wdata_i[2:0];
    end

    // Clock switch, four control bits
    if (wr_csw) begin
      st_next.csw = wdata_i[3:0];
    end

    // Mode control
    if (wr_mode) begin
      st_next.en  = new_en;
      st_next.pwm = new_pwm;
      st_next.lvl = wdata_i[`EPT_MODE_LVL];
      if (!new_en) begin
        st_next.cnt     = `EPT_RST_8;
        st_next.match_p = 1'b0;
        st_next.ovf_p   = 1'b0;
      end
      if (!new_pwm) begin
        st_next.set_p = new_set && !new_clr;
        st_next.clr_p = new_clr && !new_set;
      end
    end

    // Read data captured on a read strobe
    if (rd_en_i) begin
      st_next.rdata = rd_val;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Carrier connections
  // ----------------------------------------
  assign cif.clk_code = st_reg.clk_code;
  assign cif.code4_sw = st_reg.csw[`EPT_CSW_C4];
  assign cif.code6_sw = st_reg.csw[`EPT_CSW_C6];
  assign cif.run      = st_reg.en;
  assign cif.pwm_mode = st_reg.pwm;
  assign cif.lvl_sel  = st_reg.lvl;
  assign cif.set_p    = st_reg.set_p;
  assign cif.clr_p    = st_reg.clr_p;
  assign cif.match_p  = st_reg.match_p;
  assign cif.ovf_p    = st_reg.ovf_p;

  // ----------------------------------------
  // Count clock generation
  // ----------------------------------------
  ept_prescaler u_presc (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cif   (cif.presc)
  );

  // ----------------------------------------
  // Output flip-flops
  // ----------------------------------------
  ept_output_unit u_outu (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cif   (cif.outu)
  );

  // ----------------------------------------
  // Top-level outputs
  // ----------------------------------------
  assign rdata_o                      = st_reg.rdata;
  assign match_interrupt_request_o    = st_reg.match_p;
  assign timer_output_o               = cif.timer_ff;
  assign pwm_output_o                 = cif.pwm_pin;
  assign other_timer_a_clock_switch_o = st_reg.csw[`EPT_CSW_A];
  assign other_timer_b_clock_switch_o = st_reg.csw[`EPT_CSW_B];
endmodule
`default_nettype wire
